// ### brx_bridge.sv
/*
 documented end: inbound and outbound address translation, the outbound
 table (run-time writable in entries 0 to 255 only, never loaded when
 fixed), and both interrupt paths kept in the control register slave.
 assumes the far end holds each request stable until done and that
 fabric interrupt inputs are on this clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Contract
// R1: inbound upper bits replaced, lower kept
// R2: inbound replaced width from slave span
// R3: six inbound entries selected by BAR
// R4: outbound upper bits replaced, lower kept
// R5: outbound replaced width from total segments
// R6: up to 512 outbound segment entries
// R7: configurer gives all segments equal size
// R8: each entry has two-bit space select
// R9: upper slave address bits index table
// R10: master supplies correct index bits
// R11: table fixed or writable via slave; here only entries 0 to 255 are writable and a fixed table is never loaded
// R12: link interrupts only as MSI
// R13: interrupt logic only with register slave
// R14: irq input or mailbox sets status
// R15: link interrupt gated by enable register
// R16: irq vector loaded into link status
// R17: host clears serviced bit, rechecks
// R18: register slave has fabric level irq
// R19: fabric mailbox write sets fabric status
// R20: software enables, clears, rechecks fabric
// R21: irq held while enabled status set
// R22: write one clears status bit
module brx_bridge
#(
    parameter int  IN_SPAN_BITS = brx_pkg::IN_SPAN_BITS,
    parameter int  SEG_BITS     = brx_pkg::SEG_BITS,
    parameter int  OUT_ENTRIES  = brx_pkg::OUT_ENTRIES,
    parameter bit  DYNAMIC_TBL  = 1'b1,
    parameter bit  HAS_CRS      = 1'b1,
    parameter logic [brx_pkg::IN_ENTRIES*brx_pkg::FAB_AW-1:0] IN_TABLE = '0
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // far end
    brx_if.dev       BUS
);
    localparam int IDX_W = $clog2(OUT_ENTRIES);
    // R5: only the SEG_BITS of one segment are kept, every bit above them is replaced
    localparam int OUT_LOW = SEG_BITS;

    typedef logic [brx_pkg::PCIE_AW+brx_pkg::SP_W-1:0] brx_ent_t;

    // R6: table of segment bases plus space select
    brx_ent_t                    tbl [OUT_ENTRIES];
    logic [brx_pkg::FAB_AW-1:0]  in_fab_r;
    logic                        in_done_r;
    logic [brx_pkg::PCIE_AW-1:0] out_pcie_r;
    logic [brx_pkg::SP_W-1:0]    out_sp_r;
    logic                        out_done_r;
    logic [brx_pkg::CRS_DW-1:0]  pcie_stat_r;
    logic [brx_pkg::CRS_DW-1:0]  pcie_en_r;
    logic [brx_pkg::CRS_DW-1:0]  fab_stat_r;
    logic [brx_pkg::CRS_DW-1:0]  fab_en_r;
    logic [brx_pkg::CRS_DW-1:0]  rdata_r;
    logic                        rvalid_r;
    logic                        msi_r;
    logic                        fab_irq_r;
    logic                        pend_r;

    // R1 R2 R3: pick entry by BAR, keep low span bits
    wire [brx_pkg::FAB_AW-1:0] in_entry = IN_TABLE[BUS.in_bar*brx_pkg::FAB_AW +: brx_pkg::FAB_AW];
    wire [brx_pkg::FAB_AW-1:0] in_mask  = (brx_pkg::FAB_AW)'((64'h1 << IN_SPAN_BITS) - 64'h1);
    wire [brx_pkg::FAB_AW-1:0] in_xlat  = (in_entry & ~in_mask) | (BUS.in_addr[brx_pkg::FAB_AW-1:0] & in_mask);
    wire                       in_bar_ok = BUS.in_bar < 3'(brx_pkg::IN_ENTRIES);

    // R9 R10: index taken straight from upper slave address bits
    wire [IDX_W-1:0]           out_idx  = BUS.out_addr[OUT_LOW +: IDX_W];
    wire brx_ent_t             out_ent  = tbl[out_idx];
    wire [brx_pkg::PCIE_AW-1:0] out_mask = (brx_pkg::PCIE_AW)'((64'h1 << OUT_LOW) - 64'h1);
    // R4 R8: replace upper bits, 32-bit space clears the top word
    wire [brx_pkg::PCIE_AW-1:0] out_base = out_ent[brx_pkg::PCIE_AW-1:0];
    wire [brx_pkg::SP_W-1:0]    out_sp   = out_ent[brx_pkg::PCIE_AW +: brx_pkg::SP_W];
    wire [brx_pkg::PCIE_AW-1:0] out_raw  = (out_base & ~out_mask)
                                         | ({32'h0, BUS.out_addr} & out_mask);
    wire [brx_pkg::PCIE_AW-1:0] out_xlat = (out_sp == brx_pkg::SP_32)
                                         ? {32'h0, out_raw[31:0]} : out_raw;

    // register slave decode
    wire        tbl_hit  = HAS_CRS && !BUS.crs_addr[brx_pkg::TBL_SEL_BIT];
    wire [IDX_W-1:0] tbl_idx = BUS.crs_addr[3 +: IDX_W];
    wire        tbl_hi   = BUS.crs_addr[2];
    wire        wr       = HAS_CRS && BUS.crs_write;
    wire        w_pstat  = wr && BUS.crs_addr == brx_pkg::OFF_PCIE_STATUS;
    wire        w_pen    = wr && BUS.crs_addr == brx_pkg::OFF_PCIE_ENABLE;
    wire        w_pmbox  = wr && BUS.crs_addr == brx_pkg::OFF_PCIE_MBOX;
    wire        w_fstat  = wr && BUS.crs_addr == brx_pkg::OFF_FAB_STATUS;
    wire        w_fen    = wr && BUS.crs_addr == brx_pkg::OFF_FAB_ENABLE;
    wire        w_fmbox  = wr && BUS.crs_addr == brx_pkg::OFF_FAB_MBOX;
    wire        w_tbl    = wr && tbl_hit && DYNAMIC_TBL;

    // R14 R16: irq vector and mailbox bit raise link status
    wire [brx_pkg::CRS_DW-1:0] p_set =
        (BUS.fab_irq_in ? {24'h0, BUS.fab_irq_vec} : '0)
      | (w_pmbox ? ({24'h0, BUS.crs_wdata[brx_pkg::MBOX_W-1:0]} << brx_pkg::MBOX_BIT_LO) : '0);
    // R19: fabric mailbox write raises fabric status
    wire [brx_pkg::CRS_DW-1:0] f_set =
        w_fmbox ? ({24'h0, BUS.crs_wdata[brx_pkg::MBOX_W-1:0]} << brx_pkg::MBOX_BIT_LO) : '0;
    // R22: one clears, set beats clear
    wire [brx_pkg::CRS_DW-1:0] pcie_stat_nxt =
        (pcie_stat_r & ~(w_pstat ? BUS.crs_wdata : '0)) | p_set;
    wire [brx_pkg::CRS_DW-1:0] fab_stat_nxt =
        (fab_stat_r & ~(w_fstat ? BUS.crs_wdata : '0)) | f_set;
    // R21: pending while any enabled bit set
    wire pend_nxt = |(pcie_stat_nxt & pcie_en_r);

    wire [brx_pkg::CRS_DW-1:0] tbl_word = tbl_hi
        ? {30'h0, tbl[tbl_idx][brx_pkg::PCIE_AW +: brx_pkg::SP_W]} | tbl[tbl_idx][63:32]
        : tbl[tbl_idx][31:0];
    wire [brx_pkg::CRS_DW-1:0] rdata_nxt =
        tbl_hit                                    ? tbl_word :
        BUS.crs_addr == brx_pkg::OFF_PCIE_STATUS   ? pcie_stat_r :
        BUS.crs_addr == brx_pkg::OFF_PCIE_ENABLE   ? pcie_en_r :
        BUS.crs_addr == brx_pkg::OFF_FAB_STATUS    ? fab_stat_r :
        BUS.crs_addr == brx_pkg::OFF_FAB_ENABLE    ? fab_en_r : brx_pkg::REG_RST;

    // R11: run-time table writes, fixed table unwritable
    always_ff @(posedge CLK)
    begin
        if (w_tbl && tbl_hi)
            tbl[tbl_idx][brx_pkg::CRS_DW +: brx_pkg::SP_W + 32] <=
                {BUS.crs_wdata[31 -: brx_pkg::SP_W], BUS.crs_wdata};
        else if (w_tbl)
            tbl[tbl_idx][31:0] <= BUS.crs_wdata;
    end

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            in_fab_r   <= '0;
            in_done_r  <= 1'b0;
            out_pcie_r <= '0;
            out_sp_r   <= brx_pkg::SP_32;
            out_done_r <= 1'b0;
        end
        else
        begin
            in_fab_r   <= in_bar_ok ? in_xlat : BUS.in_addr[brx_pkg::FAB_AW-1:0];
            in_done_r  <= BUS.in_valid && !in_done_r;
            out_pcie_r <= out_xlat;
            out_sp_r   <= out_sp;
            out_done_r <= BUS.out_valid && !out_done_r;
        end
    end

    // R13: status, enable and irq logic exist only with the slave
    always_ff @(posedge CLK)
    begin
        if (!RESET_N || !HAS_CRS)
        begin
            pcie_stat_r <= brx_pkg::REG_RST;
            pcie_en_r   <= brx_pkg::REG_RST;
            fab_stat_r  <= brx_pkg::REG_RST;
            fab_en_r    <= brx_pkg::REG_RST;
            rdata_r     <= brx_pkg::REG_RST;
            rvalid_r    <= 1'b0;
            msi_r       <= 1'b0;
            pend_r      <= 1'b0;
            fab_irq_r   <= 1'b0;
        end
        else
        begin
            pcie_stat_r <= pcie_stat_nxt;
            // R15 R20: software-written enables
            pcie_en_r   <= w_pen ? BUS.crs_wdata : pcie_en_r;
            fab_en_r    <= w_fen ? BUS.crs_wdata : fab_en_r;
            fab_stat_r  <= fab_stat_nxt;
            rdata_r     <= BUS.crs_read ? rdata_nxt : rdata_r;
            rvalid_r    <= BUS.crs_read;
            pend_r      <= pend_nxt;
            // R12: one MSI pulse on each rise of pending
            msi_r       <= pend_nxt && !pend_r;
            // R18 R21: level fabric interrupt
            fab_irq_r   <= |(fab_stat_nxt & fab_en_r);
        end
    end

    assign BUS.in_fab_addr   = in_fab_r;
    assign BUS.in_done       = in_done_r;
    assign BUS.out_pcie_addr = out_pcie_r;
    assign BUS.out_space     = out_sp_r;
    assign BUS.out_done      = out_done_r;
    assign BUS.crs_rdata     = rdata_r;
    assign BUS.crs_rvalid    = rvalid_r;
    assign BUS.msi_req       = msi_r;
    assign BUS.fab_irq_out   = fab_irq_r;
endmodule // brx_bridge
`default_nettype wire

// ### brx_pkg.sv
/*
 bridge address translation and interrupt package: table sizes, register
 offsets of the control register slave, field layouts and reset values.
 assumes a single clock and a synchronous active-low reset everywhere.
*/
package brx_pkg;
    // fabric (inbound master) and link address widths
    localparam int FAB_AW       = 32;
    localparam int PCIE_AW      = 64;
    // inbound table: one entry per base address register
    localparam int IN_ENTRIES   = 6;
    localparam int BAR_W        = 3;
    // default span of all slaves on the inbound master port, as address bits
    localparam int IN_SPAN_BITS = 20;
    // outbound table
    localparam int OUT_ENTRIES  = 512;
    localparam int OUT_IDX_W    = 9;
    // default size of one outbound segment, as address bits
    localparam int SEG_BITS     = 12;
    localparam int SP_W         = 2;
    localparam logic [1:0] SP_32 = 2'h0;
    localparam logic [1:0] SP_64 = 2'h1;
    // control register slave: byte offsets
    localparam int CRS_AW       = 12;
    localparam int CRS_DW       = 32;
    // registers sit above the table window, which reaches only entries 0 to 255 of the 512
    localparam logic [11:0] OFF_PCIE_STATUS = 12'h840;
    localparam logic [11:0] OFF_PCIE_ENABLE = 12'h850;
    localparam logic [11:0] OFF_PCIE_MBOX   = 12'h800;
    localparam logic [11:0] OFF_FAB_STATUS  = 12'h860;
    localparam logic [11:0] OFF_FAB_ENABLE  = 12'h870;
    localparam logic [11:0] OFF_FAB_MBOX    = 12'h900;
    // outbound table window: entry n at TBL_BASE + 8n (low word), +4 (high word)
    localparam logic [11:0] TBL_BASE        = 12'h000;
    localparam int TBL_SEL_BIT  = 11;
    // status bit layout
    localparam int PCIE_IRQ_BIT = 0;
    localparam int MBOX_BIT_LO  = 16;
    localparam int MBOX_W       = 8;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
endpackage : brx_pkg

// ### brx_if.sv
/*
 carrier between the documented bridge end and the far-side logic end:
 inbound request address path, outbound slave address path, the control
 register slave, the three interrupt lines and the irq vector.  assumes one common clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface brx_if
(
    input wire logic CLK,
    input wire logic RESET_N
);
    // inbound request from the transaction layer
    logic                          in_valid;
    logic [brx_pkg::PCIE_AW-1:0]   in_addr;
    logic [brx_pkg::BAR_W-1:0]     in_bar;
    logic                          in_done;
    logic [brx_pkg::FAB_AW-1:0]    in_fab_addr;
    // outbound request on the slave port
    logic                          out_valid;
    logic [brx_pkg::FAB_AW-1:0]    out_addr;
    logic                          out_done;
    logic [brx_pkg::PCIE_AW-1:0]   out_pcie_addr;
    logic [brx_pkg::SP_W-1:0]      out_space;
    // control register slave
    logic                          crs_write;
    logic                          crs_read;
    logic [brx_pkg::CRS_AW-1:0]    crs_addr;
    logic [brx_pkg::CRS_DW-1:0]    crs_wdata;
    logic [brx_pkg::CRS_DW-1:0]    crs_rdata;
    logic                          crs_rvalid;
    // interrupts
    logic                          fab_irq_in;
    logic [7:0]                    fab_irq_vec;
    logic                          msi_req;
    logic                          fab_irq_out;

    modport dev
    (
        input  in_valid, in_addr, in_bar, out_valid, out_addr,
        input  crs_write, crs_read, crs_addr, crs_wdata, fab_irq_in, fab_irq_vec,
        output in_done, in_fab_addr, out_done, out_pcie_addr, out_space,
        output crs_rdata, crs_rvalid, msi_req, fab_irq_out
    );
    modport far
    (
        output in_valid, in_addr, in_bar, out_valid, out_addr,
        output crs_write, crs_read, crs_addr, crs_wdata, fab_irq_in, fab_irq_vec,
        input  in_done, in_fab_addr, out_done, out_pcie_addr, out_space,
        input  crs_rdata, crs_rvalid, msi_req, fab_irq_out
    );
endinterface : brx_if
`default_nettype wire

// ### brx_far.sv
/*
 far end: drives requests and register accesses from a plain user port.
 a request is held on the carrier until the bridge answers done.
 assumes the bridge answers each request within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module brx_far
(
    // clock and reset
    input  wire logic                        CLK,
    input  wire logic                        RESET_N,
    // inbound request
    input  wire logic                        IN_REQ,
    input  wire logic [brx_pkg::PCIE_AW-1:0] IN_ADDR,
    input  wire logic [brx_pkg::BAR_W-1:0]   IN_BAR,
    output var  logic [brx_pkg::FAB_AW-1:0]  IN_RESULT,
    output var  logic                        IN_ACK,
    // outbound request
    input  wire logic                        OUT_REQ,
    input  wire logic [brx_pkg::FAB_AW-1:0]  OUT_ADDR,
    output var  logic [brx_pkg::PCIE_AW-1:0] OUT_RESULT,
    output var  logic [brx_pkg::SP_W-1:0]    OUT_SPACE,
    output var  logic                        OUT_ACK,
    // register access
    input  wire logic                        REG_WR,
    input  wire logic                        REG_RD,
    input  wire logic [brx_pkg::CRS_AW-1:0]  REG_ADDR,
    input  wire logic [brx_pkg::CRS_DW-1:0]  REG_WDATA,
    output var  logic [brx_pkg::CRS_DW-1:0]  REG_RDATA,
    output var  logic                        REG_ACK,
    // interrupts
    input  wire logic                        IRQ_IN,
    input  wire logic [7:0]                  IRQ_VEC,
    output var  logic                        MSI_SEEN,
    output var  logic                        FAB_IRQ,
    // carrier
    brx_if.far                               BUS
);
    logic                        in_busy_r;
    logic                        out_busy_r;
    logic [brx_pkg::PCIE_AW-1:0] in_addr_r;
    logic [brx_pkg::BAR_W-1:0]   in_bar_r;
    logic [brx_pkg::FAB_AW-1:0]  out_addr_r;
    logic                        wr_r;
    logic                        rd_r;
    logic [brx_pkg::CRS_AW-1:0]  raddr_r;
    logic [brx_pkg::CRS_DW-1:0]  wdata_r;
    logic                        irq_r;
    logic [7:0]                  vec_r;

    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            in_busy_r  <= 1'b0;
            out_busy_r <= 1'b0;
            in_addr_r  <= '0;
            in_bar_r   <= '0;
            out_addr_r <= '0;
            wr_r       <= 1'b0;
            rd_r       <= 1'b0;
            raddr_r    <= '0;
            wdata_r    <= '0;
            irq_r      <= 1'b0;
            vec_r      <= '0;
            IN_RESULT  <= '0;
            IN_ACK     <= 1'b0;
            OUT_RESULT <= '0;
            OUT_SPACE  <= '0;
            OUT_ACK    <= 1'b0;
            REG_RDATA  <= '0;
            REG_ACK    <= 1'b0;
            MSI_SEEN   <= 1'b0;
            FAB_IRQ    <= 1'b0;
        end
        else
        begin
            if (IN_REQ && !in_busy_r)
            begin
                in_busy_r <= 1'b1;
                in_addr_r <= IN_ADDR;
                in_bar_r  <= IN_BAR;
            end
            else if (BUS.in_done)
                in_busy_r <= 1'b0;
            // R10: caller's address carries the table index as given
            if (OUT_REQ && !out_busy_r)
            begin
                out_busy_r <= 1'b1;
                out_addr_r <= OUT_ADDR;
            end
            else if (BUS.out_done)
                out_busy_r <= 1'b0;
            // R7 R17 R20: software sequencing is the user's, passed one access a cycle
            wr_r       <= REG_WR;
            rd_r       <= REG_RD && !REG_WR;
            raddr_r    <= REG_ADDR;
            wdata_r    <= REG_WDATA;
            irq_r      <= IRQ_IN;
            vec_r      <= IRQ_VEC;
            IN_ACK     <= BUS.in_done;
            IN_RESULT  <= BUS.in_done ? BUS.in_fab_addr : IN_RESULT;
            OUT_ACK    <= BUS.out_done;
            OUT_RESULT <= BUS.out_done ? BUS.out_pcie_addr : OUT_RESULT;
            OUT_SPACE  <= BUS.out_done ? BUS.out_space : OUT_SPACE;
            REG_ACK    <= BUS.crs_rvalid;
            REG_RDATA  <= BUS.crs_rvalid ? BUS.crs_rdata : REG_RDATA;
            MSI_SEEN   <= BUS.msi_req;
            FAB_IRQ    <= BUS.fab_irq_out;
        end
    end

    assign BUS.in_valid    = in_busy_r;
    assign BUS.in_addr     = in_addr_r;
    assign BUS.in_bar      = in_bar_r;
    assign BUS.out_valid   = out_busy_r;
    assign BUS.out_addr    = out_addr_r;
    assign BUS.crs_write   = wr_r;
    assign BUS.crs_read    = rd_r;
    assign BUS.crs_addr    = raddr_r;
    assign BUS.crs_wdata   = wdata_r;
    assign BUS.fab_irq_in  = irq_r;
    assign BUS.fab_irq_vec = vec_r;
endmodule // brx_far
`default_nettype wire

// ### brx_assertions.sv
/*
 checker on the carrier between bridge and far end: translation timing,
 register answers and interrupt causes.
 assumes one clock and the carrier signals wired in by name.
*/
`timescale 1ns/1ps
`default_nettype none
module brx_assertions
#(
    parameter int           IN_SPAN_BITS = brx_pkg::IN_SPAN_BITS,
    parameter int           SEG_BITS     = brx_pkg::SEG_BITS,
    parameter logic [191:0] IN_TABLE     = '0
)
(
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // inbound path
    input wire logic        in_valid,
    input wire logic [63:0] in_addr,
    input wire logic [2:0]  in_bar,
    input wire logic        in_done,
    input wire logic [31:0] in_fab_addr,
    // outbound path
    input wire logic        out_valid,
    input wire logic [31:0] out_addr,
    input wire logic        out_done,
    input wire logic [63:0] out_pcie_addr,
    input wire logic [1:0]  out_space,
    // register slave and interrupts
    input wire logic        crs_write,
    input wire logic        crs_read,
    input wire logic [11:0] crs_addr,
    input wire logic [31:0] crs_rdata,
    input wire logic        crs_rvalid,
    input wire logic        fab_irq_in,
    input wire logic        msi_req,
    input wire logic        fab_irq_out
);
    localparam logic [31:0] MSK = (32'h1 << IN_SPAN_BITS) - 32'h1;
    // only meaningful for bar 0..5; guarded in the properties
    wire logic [31:0] tbl_sel = IN_TABLE[32*in_bar +: 32];
    wire logic        cause   = crs_write || fab_irq_in;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    in_done_a: assert property (in_valid && !in_done |=> in_done)
        else $error("inbound request not answered");
    in_xlate_a: assert property (in_valid && !in_done && in_bar < 3'd6 |=>
        in_fab_addr == (($past(tbl_sel) & ~MSK) | ($past(in_addr[31:0]) & MSK)))
        else $error("inbound address not translated");
    in_pass_a: assert property (in_valid && !in_done && in_bar > 3'd5 |=>
        in_fab_addr == $past(in_addr[31:0]))
        else $error("inbound address without entry changed");
    out_done_a: assert property (out_valid && !out_done |=> out_done)
        else $error("outbound request not answered");
    out_low_a: assert property (out_valid && !out_done |=>
        out_pcie_addr[SEG_BITS-1:0] == $past(out_addr[SEG_BITS-1:0]))
        else $error("outbound low address bits changed");
    space_narrow_a: assert property (out_done && out_space == brx_pkg::SP_32 |->
        out_pcie_addr[63:32] == 32'h0)
        else $error("narrow space with upper address bits");
    rd_answer_a: assert property (crs_read |=> crs_rvalid)
        else $error("register read not answered");
    unmapped_zero_a: assert property (crs_read && crs_addr == 12'hff0 |=> crs_rdata == 32'h0)
        else $error("unmapped read not zero");
    msi_cause_a: assert property (msi_req |-> $past(cause) || $past(cause, 2) || $past(cause, 3))
        else $error("message interrupt without cause");
    msi_pulse_a: assert property (msi_req |=> !msi_req)
        else $error("message interrupt longer than one cycle");
    irq_rise_a: assert property ($rose(fab_irq_out) |->
        $past(crs_write) || $past(crs_write, 2) || $past(crs_write, 3))
        else $error("fabric interrupt rose without write");
    irq_fall_a: assert property ($fell(fab_irq_out) |->
        $past(crs_write) || $past(crs_write, 2) || $past(crs_write, 3))
        else $error("fabric interrupt fell without write");
endmodule // brx_assertions
`default_nettype wire

// ### tb.sv
/*
 testbench: both ends joined by the carrier, driven from the far end's
 user ports with register, inbound and outbound calls.
 assumes every far-end request is acknowledged within a few cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [191:0] IN_TBL = {32'hb5a0_0000, 32'ha4b0_0000, 32'h93c0_0000,
                                       32'h82d0_0000, 32'h71e0_0000, 32'h60f0_0000};
    localparam logic [31:0]  MSK    = (32'h1 << brx_pkg::IN_SPAN_BITS) - 32'h1;
    localparam logic [31:0]  LO0    = 32'h1234_5000;
    localparam logic [31:0]  HI0    = 32'h0000_0abc;
    localparam logic [31:0]  LO1    = 32'hfeed_c000;
    localparam logic [31:0]  HI1    = 32'h4000_0010;

    logic        clk       = 1'b0;
    logic        reset_n   = 1'b0;
    logic        in_req    = 1'b0;
    logic [63:0] in_addr   = 64'h0;
    logic [2:0]  in_bar    = 3'h0;
    logic        out_req   = 1'b0;
    logic [31:0] out_addr  = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [11:0] reg_addr  = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        irq_in    = 1'b0;
    logic [7:0]  irq_vec   = 8'h0;
    logic [31:0] in_res, reg_rdata, rd_val;
    logic [63:0] out_res;
    logic [1:0]  out_sp;
    logic        in_ack, out_ack, reg_ack, msi_seen, fab_irq;
    int          error_cnt = 0;
    int          num_checks = 0;
    int          msi_cnt = 0;
    int          cyc = 0;

    always #2 clk = ~clk;

    brx_if u_brx_if (.CLK(clk), .RESET_N(reset_n));
    brx_bridge #(.IN_TABLE(IN_TBL)) u_brx_bridge (.CLK(clk), .RESET_N(reset_n), .BUS(u_brx_if));
    brx_far u_brx_far (.CLK(clk), .RESET_N(reset_n), .BUS(u_brx_if),
        .IN_REQ(in_req), .IN_ADDR(in_addr), .IN_BAR(in_bar), .IN_RESULT(in_res), .IN_ACK(in_ack),
        .OUT_REQ(out_req), .OUT_ADDR(out_addr), .OUT_RESULT(out_res), .OUT_SPACE(out_sp),
        .OUT_ACK(out_ack), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_ACK(reg_ack),
        .IRQ_IN(irq_in), .IRQ_VEC(irq_vec), .MSI_SEEN(msi_seen), .FAB_IRQ(fab_irq));
    brx_assertions #(.IN_TABLE(IN_TBL)) u_brx_assertions (.CLK(clk), .RESET_N(reset_n),
        .in_valid(u_brx_if.in_valid), .in_addr(u_brx_if.in_addr), .in_bar(u_brx_if.in_bar),
        .in_done(u_brx_if.in_done), .in_fab_addr(u_brx_if.in_fab_addr),
        .out_valid(u_brx_if.out_valid), .out_addr(u_brx_if.out_addr),
        .out_done(u_brx_if.out_done), .out_pcie_addr(u_brx_if.out_pcie_addr),
        .out_space(u_brx_if.out_space), .crs_write(u_brx_if.crs_write),
        .crs_read(u_brx_if.crs_read), .crs_addr(u_brx_if.crs_addr),
        .crs_rdata(u_brx_if.crs_rdata), .crs_rvalid(u_brx_if.crs_rvalid),
        .fab_irq_in(u_brx_if.fab_irq_in), .msi_req(u_brx_if.msi_req),
        .fab_irq_out(u_brx_if.fab_irq_out));

    task automatic end_of_test;
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // returns at the falling edge that follows the acknowledge
    task automatic wait_ack(input int s);
        int   n;
        logic a;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            a = (s == 0) ? in_ack : (s == 1) ? out_ack : reg_ack;
        end while (a !== 1'b1 && n < 30);
        if (a !== 1'b1)
            check("acknowledge", 64'h0, 64'h1);
    endtask

    task automatic reg_op(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        // one-cycle strobe: the far end latches it, a held strobe repeats the access
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        if (!w)
            wait_ack(2);
        rd_val = reg_rdata;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        reg_op(1'b0, a, 32'h0);
        check($sformatf("register %h", a), {32'h0, rd_val}, {32'h0, e});
    endtask

    task automatic in_chk(input logic [2:0] b, input logic [63:0] a);
        logic [31:0] e;
        e = (b < 3'd6) ? ((IN_TBL[32*b +: 32] & ~MSK) | (a[31:0] & MSK)) : a[31:0];
        @(negedge clk);
        in_addr = a;
        in_bar = b;
        in_req = 1'b1;
        @(negedge clk);
        in_req = 1'b0;
        wait_ack(0);
        check($sformatf("inbound bar %0d", b), {32'h0, in_res}, {32'h0, e});
    endtask

    task automatic out_chk(input logic [31:0] a, input logic [63:0] e, input logic [1:0] sp);
        @(negedge clk);
        out_addr = a;
        out_req = 1'b1;
        @(negedge clk);
        out_req = 1'b0;
        wait_ack(1);
        check("outbound address", out_res, e);
        check("outbound space", {62'h0, out_sp}, {62'h0, sp});
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (msi_seen === 1'b1)
            msi_cnt <= msi_cnt + 1;
        // the whole sequence needs well under a thousand cycles
        if (cyc == 3000)
        begin
            error_cnt = error_cnt + 1;
            end_of_test();
        end
    end

    initial
    begin
        logic [11:0] offs [5];
        offs = '{brx_pkg::OFF_PCIE_STATUS, brx_pkg::OFF_PCIE_ENABLE, brx_pkg::OFF_FAB_STATUS,
                 brx_pkg::OFF_FAB_ENABLE, 12'hff0};
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 5; i++)
            rd_chk(offs[i], brx_pkg::REG_RST);
        for (int b = 0; b < 7; b++)
            in_chk(3'(b), 64'h1111_2222_3345_6780 + 64'(b));
        // first and last entry that the register window reaches
        reg_op(1'b1, 12'h000, LO0);
        reg_op(1'b1, 12'h004, HI0);
        reg_op(1'b1, 12'h7f8, LO1);
        reg_op(1'b1, 12'h7fc, HI1);
        rd_chk(12'h7f8, LO1);
        rd_chk(12'h7fc, HI1 | 32'h1);
        out_chk(32'h0000_0abc, {32'h0, LO0[31:12], 12'habc}, brx_pkg::SP_32);
        out_chk(32'h000f_f123, {HI1, LO1[31:12], 12'h123}, brx_pkg::SP_64);
        @(negedge clk);
        irq_vec = 8'h05;
        irq_in = 1'b1;
        repeat (2) @(negedge clk);
        irq_in = 1'b0;
        repeat (8) @(negedge clk);
        check("msi while disabled", 64'(msi_cnt), 64'h0);
        rd_chk(brx_pkg::OFF_PCIE_STATUS, 32'h0000_0005);
        reg_op(1'b1, brx_pkg::OFF_PCIE_STATUS, 32'h0000_0001);
        rd_chk(brx_pkg::OFF_PCIE_STATUS, 32'h0000_0004);
        reg_op(1'b1, brx_pkg::OFF_PCIE_STATUS, 32'h0000_0004);
        reg_op(1'b1, brx_pkg::OFF_PCIE_ENABLE, 32'hffff_ffff);
        reg_op(1'b1, brx_pkg::OFF_PCIE_MBOX, 32'h0000_003c);
        repeat (8) @(negedge clk);
        check("msi after mailbox", 64'(msi_cnt), 64'h1);
        rd_chk(brx_pkg::OFF_PCIE_STATUS, 32'h003c_0000);
        reg_op(1'b1, brx_pkg::OFF_FAB_MBOX, 32'h0000_0081);
        repeat (8) @(negedge clk);
        check("fabric irq disabled", {63'h0, fab_irq}, 64'h0);
        rd_chk(brx_pkg::OFF_FAB_STATUS, 32'h0081_0000);
        reg_op(1'b1, brx_pkg::OFF_FAB_ENABLE, 32'hffff_ffff);
        repeat (8) @(negedge clk);
        check("fabric irq enabled", {63'h0, fab_irq}, 64'h1);
        reg_op(1'b1, brx_pkg::OFF_FAB_STATUS, 32'h0001_0000);
        repeat (8) @(negedge clk);
        check("fabric irq one left", {63'h0, fab_irq}, 64'h1);
        reg_op(1'b1, brx_pkg::OFF_FAB_STATUS, 32'h0080_0000);
        repeat (8) @(negedge clk);
        check("fabric irq cleared", {63'h0, fab_irq}, 64'h0);
        end_of_test();
    end
endmodule // tb
`default_nettype wire
